// file: sim/asfe_engine_bench.sv
`timescale 1ns/1ns
module asfe_engine_bench;
  logic       sys_clk;
  logic       rst_n;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  wire  [7:0] reg_rdata;
  wire        rxd;
  wire        txd;
  wire        txd_oe;
  wire        serv_req;
  wire  [8:0] got_word;
  int         got_count;
  int         got_bad;
  int         bad_count  = 0;
  int         n_compared = 0;

  asfe_engine #(.BASE_DIV(16'h0001)) i_asfe_engine (
    .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rxd(rxd),
    .txd(txd), .txd_oe(txd_oe), .serv_req(serv_req)
  );

  asfe_far_end i_asfe_far_end (
    .sys_clk(sys_clk), .line_out(rxd), .line_in(txd),
    .got_word(got_word), .got_count(got_count), .got_bad(got_bad)
  );

  // ========
  // Access tasks
  task automatic give_verdict;
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic expect_reg(input logic [2:0] a, input logic [7:0] e);
    logic [7:0] v;
    rd(a, v);
    check(v, e);
  endtask

  // The idle flag is masked because its timing depends on gaps between tests.
  task automatic get_char(input logic [7:0] st, input logic [7:0] d);
    logic [7:0] s;
    s = 8'h00;
    for (int n = 0; n < 400 && s[5] !== 1'b1; n++)
      rd(3'h3, s);
    if (s[5] !== 1'b1)
    begin
      bad_count++;
      give_verdict();
    end
    check(serv_req, 1'b1);
    check(s & 8'h2E, st);
    expect_reg(3'h0, d);
  endtask

  task automatic quiet;
    logic [7:0] s;
    rd(3'h3, s);
    check(s[5], 1'b0);
    check(serv_req, 1'b0);
  endtask

  task automatic wait_tx(input int n, input logic [8:0] w);
    for (int k = 0; k < 2000 && got_count < n; k++)
      @(posedge sys_clk);
    if (got_count < n)
    begin
      bad_count++;
      give_verdict();
    end
    check(got_count == n && got_bad == 0, 1'b1);
    check(got_word, w);
  endtask

  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // ========
  // Main sequence
  initial
  begin
    rst_n     = 1'b0;
    reg_addr  = 3'h0;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    #1;
    check({txd, txd_oe}, 2'h2);
    expect_reg(3'h3, 8'hC0);
    expect_reg(3'h2, 8'h00);
    expect_reg(3'h5, 8'h00);
    wr(3'h4, 8'h01);
    i_asfe_far_end.bit_clks = 32;
    wr(3'h2, 8'h2C);
    wr(3'h0, 8'hA5);
    fork
      i_asfe_far_end.send(9'h03C, 1'b1, 1'b0);
    join_none
    get_char(8'h20, 8'h3C);
    wait_tx(1, 9'h0A5);
    wr(3'h4, 8'h00);
    i_asfe_far_end.bit_clks = 16;
    i_asfe_far_end.nbits = 9;
    wr(3'h1, 8'h50);
    wr(3'h0, 8'h3C);
    fork
      i_asfe_far_end.send(9'h1C3, 1'b1, 1'b0);
    join_none
    get_char(8'h20, 8'hC3);
    expect_reg(3'h1, 8'hD0);
    wait_tx(2, 9'h13C);
    i_asfe_far_end.nbits = 8;
    wr(3'h1, 8'h00);
    fork
      i_asfe_far_end.send(9'h0F0, 1'b1, 1'b1);
    join_none
    get_char(8'h24, 8'hF0);
    fork
    begin
      i_asfe_far_end.send(9'h055, 1'b0, 1'b0);
      i_asfe_far_end.send(9'h0AA, 1'b1, 1'b0);
    end
    join_none
    get_char(8'h22, 8'h55);
    get_char(8'h20, 8'hAA);
    i_asfe_far_end.hold_low(192);
    get_char(8'h22, 8'h00);
    fork
      i_asfe_far_end.send(9'h05A, 1'b1, 1'b0);
    join_none
    get_char(8'h20, 8'h5A);
    i_asfe_far_end.hold_low(3);
    repeat (176) @(posedge sys_clk);
    quiet();
    fork
    begin
      i_asfe_far_end.send(9'h011, 1'b1, 1'b0);
      i_asfe_far_end.send(9'h022, 1'b1, 1'b0);
      i_asfe_far_end.send(9'h033, 1'b1, 1'b0);
    end
    join_none
    get_char(8'h20, 8'h11);
    wr(3'h2, 8'h2E);
    repeat (340) @(posedge sys_clk);
    quiet();
    expect_reg(3'h2, 8'h2E);
    repeat (200) @(posedge sys_clk);
    expect_reg(3'h2, 8'h2C);
    wr(3'h1, 8'h08);
    wr(3'h2, 8'h2E);
    fork
      i_asfe_far_end.send(9'h005, 1'b1, 1'b0);
    join_none
    repeat (340) @(posedge sys_clk);
    quiet();
    expect_reg(3'h2, 8'h2E);
    fork
      i_asfe_far_end.send(9'h085, 1'b1, 1'b0);
    join_none
    get_char(8'h20, 8'h85);
    expect_reg(3'h2, 8'h2C);
    wr(3'h2, 8'h00);
    repeat (2) @(posedge sys_clk);
    check({txd, txd_oe}, 2'h2);
    give_verdict();
  end
endmodule // asfe_engine_bench

// file: sim/asfe_engine_props.sv
`timescale 1ns/1ns
// ========
// Port checker
module asfe_engine_props #(
  parameter [15:0] BASE_DIV = 16'h0001
) (
  input wire       sys_clk,
  input wire       rst_n,
  input wire [2:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire       reg_wr,
  input wire       reg_rd,
  input wire [7:0] reg_rdata,
  input wire       rxd,
  input wire       txd,
  input wire       txd_oe,
  input wire       serv_req
);
  reg  [4:0]  rate_r;
  reg  [7:0]  c1_r;
  reg  [7:0]  c2_r;
  reg  [15:0] low_r;
  wire [31:0] bitc;
  wire [31:0] maxc;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // A shadow of the control writes lets bit lengths be judged at any rate.
  assign bitc = 32'h10 * (rate_r + 32'h1) * BASE_DIV;
  assign maxc = (c1_r[4] ? 32'hA : 32'h9) * bitc;

  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rate_r <= 5'h00;
      c1_r   <= 8'h00;
      c2_r   <= 8'h00;
      low_r  <= 16'h0000;
    end
    else
    begin
      if (reg_wr && reg_addr == 3'h1)
        c1_r <= reg_wdata;
      if (reg_wr && reg_addr == 3'h2)
        c2_r <= reg_wdata;
      if (reg_wr && reg_addr == 3'h4)
        rate_r <= reg_wdata[4:0];
      low_r <= txd ? 16'h0000 : low_r + 16'h0001;
    end
  end

  property p_idle_high;
    !txd_oe |-> txd;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("line low while undriven");

  property p_oe_release;
    $fell(txd_oe) |-> txd && $past(txd);
  endproperty
  a_oe_release: assert property (p_oe_release) else $error("line released mid bit");

  property p_te_oe;
    reg_wr && reg_addr == 3'h2 && reg_wdata[3] |=> txd_oe;
  endproperty
  a_te_oe: assert property (p_te_oe) else $error("enable did not drive line");

  property p_low_mult;
    $rose(txd) |-> (low_r % bitc) == 32'h0;
  endproperty
  a_low_mult: assert property (p_low_mult) else $error("low run not whole bits");

  property p_low_max;
    !txd |-> low_r < maxc;
  endproperty
  a_low_max: assert property (p_low_max) else $error("low run longer than frame");

  property p_serv_gate;
    c2_r[7:4] == 4'h0 |-> !serv_req;
  endproperty
  a_serv_gate: assert property (p_serv_gate) else $error("request with enables off");

  property p_c1_read;
    $past(reg_rd && reg_addr == 3'h1) |-> reg_rdata[4:3] == c1_r[4:3];
  endproperty
  a_c1_read: assert property (p_c1_read) else $error("format readback wrong");

  property p_c2_read;
    $past(reg_rd && reg_addr == 3'h2) |-> reg_rdata[7:2] == c2_r[7:2];
  endproperty
  a_c2_read: assert property (p_c2_read) else $error("enable readback wrong");

  property p_rate_read;
    $past(reg_rd && reg_addr == 3'h4) |-> reg_rdata[4:0] == rate_r;
  endproperty
  a_rate_read: assert property (p_rate_read) else $error("rate readback wrong");

  c_frame: cover property ($rose(txd) && txd_oe);
  c_serv: cover property ($rose(serv_req));
  c_nine: cover property ($past(reg_rd && reg_addr == 3'h1) && reg_rdata[7]);
endmodule // asfe_engine_props

bind asfe_engine asfe_engine_props #(.BASE_DIV(BASE_DIV)) i_asfe_engine_props (
  .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rxd(rxd),
  .txd(txd), .txd_oe(txd_oe), .serv_req(serv_req)
);

// file: sim/asfe_far_end.sv
`timescale 1ns/1ns
// ========
// Remote serial station
module asfe_far_end (
  // Clock
  input  wire        sys_clk,
  // Serial wires
  output logic       line_out,
  input  wire        line_in,
  // Received traffic
  output logic [8:0] got_word,
  output int         got_count,
  output int         got_bad
);
  int bit_clks = 16;
  int nbits    = 8;

  initial
    line_out = 1'b1;

  // The line is left at the stop level so a following frame can start at once.
  task automatic send(input logic [8:0] d, input logic stop, input logic blip);
    int i;
    int k;
    for (i = 0; i < nbits + 2; i++)
      for (k = 0; k < bit_clks; k++)
      begin
        @(posedge sys_clk);
        if (i == 0)
          // The blip lands on the first start verification sample.
          line_out <= blip && (k == 3 || k == 4);
        else if (i <= nbits)
          line_out <= d[i-1];
        else
          line_out <= stop;
      end
  endtask

  task automatic hold_low(input int clks);
    @(posedge sys_clk);
    line_out <= 1'b0;
    repeat (clks) @(posedge sys_clk);
    line_out <= 1'b1;
  endtask

  initial
  begin
    got_count = 0;
    got_bad   = 0;
    got_word  = 9'h000;
    forever
    begin
      @(negedge line_in);
      got_word = 9'h000;
      repeat (bit_clks / 2) @(posedge sys_clk);
      for (int j = 0; j < nbits; j++)
      begin
        repeat (bit_clks) @(posedge sys_clk);
        got_word[j] = line_in;
      end
      repeat (bit_clks) @(posedge sys_clk);
      if (line_in !== 1'b1)
        got_bad++;
      got_count++;
    end
  end
endmodule // asfe_far_end

// file: verilog/asfe_defines.vh
`ifndef ASFE_DEFINES_VH
`define ASFE_DEFINES_VH
// ==========================================================
// Register indices
`define ASFE_REG_DATA  3'h0
`define ASFE_REG_CTRL1 3'h1
`define ASFE_REG_CTRL2 3'h2
`define ASFE_REG_STAT  3'h3
`define ASFE_REG_RATE  3'h4
// ==========================================================
// Control one fields
`define ASFE_C1_RXB8  7
`define ASFE_C1_TXB8  6
`define ASFE_C1_LEN9  4
`define ASFE_C1_WAKE  3
// ==========================================================
// Control two fields
`define ASFE_C2_TIE   7
`define ASFE_C2_TCIE  6
`define ASFE_C2_RIE   5
`define ASFE_C2_ILIE  4
`define ASFE_C2_TE    3
`define ASFE_C2_RE    2
`define ASFE_C2_SLEEP 1
`define ASFE_C2_SBK   0
// ==========================================================
// Status fields
`define ASFE_ST_TDRE  7
`define ASFE_ST_TC    6
`define ASFE_ST_RDRF  5
`define ASFE_ST_IDLE  4
`define ASFE_ST_OVR   3
`define ASFE_ST_NF    2
`define ASFE_ST_FE    1
// ==========================================================
// Reset values
`define ASFE_RST_CTRL2 8'h00
`define ASFE_RST_RATE  5'h00
// ==========================================================
// Timing counts in oversample ticks; frame lengths in bits
`define ASFE_RT_PER_BIT 4'hF
`define ASFE_RT_VER1    4'h3
`define ASFE_RT_VER2    4'h5
`define ASFE_RT_VER3    4'h7
`define ASFE_RT_S8      4'h8
`define ASFE_RT_S9      4'h9
`define ASFE_RT_S10     4'hA
`define ASFE_FRAME8     4'hA
`define ASFE_FRAME9     4'hB
`endif

// file: verilog/asfe_engine.v
`timescale 1ns/1ns
`include "asfe_defines.vh"

// Function
// - Frame is one low start bit, data, one high stop bit; idle line high.
// - Data bits go out and come in least significant bit first.
// - Character holds eight or nine data bits, shared by both directions.
// - Break means line low for at least one whole frame.
// - Transmitter and receiver run independently on one format and rate.
// - Software picks one of thirty-two bit rates.
// - Receiver samples on a tick at sixteen times the bit rate.
// - Each bit is voted from samples at ticks eight, nine and ten.
// - Low line gets three verify samples; two zeros accept a start bit.
// - Noise flag set when verify samples are not all zero.
// - Break is ten zeros with eight bits, eleven with nine.
// - Non-break framing error acts as a stop; last bit forced to one.
// - After an artificial start, a new start is never accepted early.
// - After a break, the line must be seen high before any start.
// - Sleeping receiver wakes by idle line or address mark, per setting.
// - Idle wake needs ten or eleven full bit times of high line.
// - Address wake treats a character with top bit set as an address.
// - While asleep, received characters other than a waking address raise no service request.
// - Transmit bit period is sixteen oversample ticks.
// - Four enables gate transmit, complete, receive and idle requests.
// - Length setting zero gives eight bits, one gives nine.
// - Hardware clears the sleep request on idle or on an address character.
module asfe_engine #(
  parameter [15:0] BASE_DIV = 16'h0001
) (
  // Clock and reset
  input  wire       sys_clk,
  input  wire       rst_n,
  // Register port
  input  wire [2:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata,
  // Serial line
  input  wire       rxd,
  output wire       txd,
  output wire       txd_oe,
  // Service request
  output wire       serv_req
);

  localparam RX_HUNT  = 2'h0;
  localparam RX_FRAME = 2'h1;
  localparam RX_WAIT  = 2'h2;

  // ==========================================================
  // Registers
  reg  [7:0]  ctrl2_r;
  reg  [4:0]  rate_r;
  reg         len9_r;
  reg         wake_addr_r;
  reg         txb8_r;
  reg  [7:0]  tx_hold_r;
  reg         tdre_r;
  reg         tc_r;
  reg  [7:0]  rx_data_r;
  reg         rxb8_r;
  reg         rdrf_r;
  reg         idle_r;
  reg         ovr_r;
  reg         nf_r;
  reg         fe_r;
  reg         clr_arm_r;
  reg         te_d_r;

  wire        wr_data  = reg_wr & (reg_addr == `ASFE_REG_DATA);
  wire        wr_ctrl1 = reg_wr & (reg_addr == `ASFE_REG_CTRL1);
  wire        wr_ctrl2 = reg_wr & (reg_addr == `ASFE_REG_CTRL2);
  wire        wr_rate  = reg_wr & (reg_addr == `ASFE_REG_RATE);
  wire        rd_data  = reg_rd & (reg_addr == `ASFE_REG_DATA);
  wire        rd_stat  = reg_rd & (reg_addr == `ASFE_REG_STAT);
  wire        te       = ctrl2_r[`ASFE_C2_TE];
  wire        re       = ctrl2_r[`ASFE_C2_RE];
  wire        sleep    = ctrl2_r[`ASFE_C2_SLEEP];
  wire [3:0]  frame_len = len9_r ? `ASFE_FRAME9 : `ASFE_FRAME8;
  wire [7:0]  stat_w = {tdre_r, tc_r, rdrf_r, idle_r, ovr_r, nf_r, fe_r, 1'b0};

  // ==========================================================
  // Oversample tick generator
  reg  [15:0] div_cnt_r;
  reg         rt_tick;
  wire [15:0] div_load = ({11'h000, rate_r} + 16'h0001) * BASE_DIV;

  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div_cnt_r <= 16'h0000;
      rt_tick   <= 1'b0;
    end
    else if (div_cnt_r >= div_load - 16'h0001)
    begin
      div_cnt_r <= 16'h0000;
      rt_tick   <= 1'b1;
    end
    else
    begin
      div_cnt_r <= div_cnt_r + 16'h0001;
      rt_tick   <= 1'b0;
    end
  end

  // ==========================================================
  // Receive line synchroniser
  reg         rx_m_r;
  reg         rx_s_r;

  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_m_r <= 1'b1;
      rx_s_r <= 1'b1;
    end
    else
    begin
      rx_m_r <= rxd;
      rx_s_r <= rx_m_r;
    end
  end

  // ==========================================================
  // Receiver
  reg  [1:0]  rx_st_r;
  reg  [3:0]  rx_rt_r;
  reg  [3:0]  rx_bit_r;
  reg  [1:0]  ver_zero_r;
  reg         s8_r;
  reg         s9_r;
  reg  [8:0]  rx_sh_r;
  reg         rx_noise_r;
  reg         need_high_r;
  reg  [7:0]  idle_cnt_r;
  reg         char_seen_r;
  reg         rx_done;
  reg         rx_ferr;
  reg         rx_idle_ev;
  wire        vote = (s8_r & s9_r) | (s8_r & rx_s_r) | (s9_r & rx_s_r);
  wire        disagree = ~((s8_r == s9_r) & (s9_r == rx_s_r));
  wire        msb_in = len9_r ? rx_sh_r[8] : rx_sh_r[7];
  wire [7:0]  idle_need = {frame_len, 4'h0};

  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_st_r     <= RX_HUNT;
      rx_rt_r     <= 4'h0;
      rx_bit_r    <= 4'h0;
      ver_zero_r  <= 2'h0;
      s8_r        <= 1'b1;
      s9_r        <= 1'b1;
      rx_sh_r     <= 9'h000;
      rx_noise_r  <= 1'b0;
      need_high_r <= 1'b0;
      idle_cnt_r  <= 8'h00;
      rx_done     <= 1'b0;
      rx_ferr     <= 1'b0;
      rx_idle_ev  <= 1'b0;
    end
    else
    begin
      rx_done    <= 1'b0;
      rx_idle_ev <= 1'b0;
      if (!re)
      begin
        rx_st_r     <= RX_HUNT;
        need_high_r <= 1'b0;
        idle_cnt_r  <= 8'h00;
      end
      else if (rt_tick)
      begin
        case (rx_st_r)
          RX_HUNT:
          begin
            if (rx_s_r)
            begin
              need_high_r <= 1'b0;
              if (idle_cnt_r != 8'hFF)
                idle_cnt_r <= idle_cnt_r + 8'h01;
              if (idle_cnt_r + 8'h01 == idle_need)
                rx_idle_ev <= 1'b1;
            end
            else
            begin
              idle_cnt_r <= 8'h00;
              if (!need_high_r)
              begin
                rx_st_r    <= RX_FRAME;
                rx_rt_r    <= 4'h1;
                rx_bit_r   <= 4'h0;
                ver_zero_r <= 2'h0;
                rx_noise_r <= 1'b0;
                // Clearing here keeps a stale ninth bit out of break detection.
                rx_sh_r    <= 9'h000;
              end
            end
          end
          RX_FRAME:
          begin
            rx_rt_r <= rx_rt_r + 4'h1;
            if ((rx_bit_r == 4'h0) && ((rx_rt_r == `ASFE_RT_VER1) ||
                (rx_rt_r == `ASFE_RT_VER2) || (rx_rt_r == `ASFE_RT_VER3)))
            begin
              if (!rx_s_r)
                ver_zero_r <= ver_zero_r + 2'h1;
              else
                rx_noise_r <= 1'b1;
              if ((rx_rt_r == `ASFE_RT_VER3) &&
                  ((ver_zero_r + {1'b0, ~rx_s_r}) < 2'h2))
                rx_st_r <= RX_HUNT;
            end
            if (rx_rt_r == `ASFE_RT_S8)
              s8_r <= rx_s_r;
            if (rx_rt_r == `ASFE_RT_S9)
              s9_r <= rx_s_r;
            if (rx_rt_r == `ASFE_RT_S10)
            begin
              if (disagree)
                rx_noise_r <= 1'b1;
              if (rx_bit_r == 4'h0)
              begin
                if (vote)
                  rx_st_r <= RX_HUNT;
              end
              else if (rx_bit_r < frame_len - 4'h1)
                rx_sh_r[rx_bit_r - 4'h1] <= vote;
              else
              begin
                rx_done   <= 1'b1;
                rx_ferr   <= ~vote;
                rx_st_r   <= RX_WAIT;
                if (!vote && (rx_sh_r == 9'h000))
                  need_high_r <= 1'b1;
              end
            end
            if (rx_rt_r == `ASFE_RT_PER_BIT)
            begin
              rx_rt_r  <= 4'h0;
              rx_bit_r <= rx_bit_r + 4'h1;
            end
          end
          RX_WAIT:
          begin
            rx_rt_r    <= rx_rt_r + 4'h1;
            idle_cnt_r <= 8'h00;
            if (rx_rt_r == `ASFE_RT_PER_BIT)
              rx_st_r <= RX_HUNT;
          end
          default:
            rx_st_r <= RX_HUNT;
        endcase
      end
    end
  end

  // ==========================================================
  // Transmitter
  reg  [10:0] tx_sh_r;
  reg  [3:0]  tx_cnt_r;
  reg  [3:0]  tx_rt_r;
  reg         tx_busy_r;
  reg         pre_pend_r;
  reg         post_brk_r;
  wire        bit_stb = rt_tick & (tx_rt_r == `ASFE_RT_PER_BIT);
  wire        sbk = ctrl2_r[`ASFE_C2_SBK];
  wire        last_bit = ~tx_busy_r | (tx_cnt_r == 4'h1);
  reg         tx_load;
  reg         tx_done;

  assign txd    = tx_busy_r ? tx_sh_r[0] : 1'b1;
  assign txd_oe = te | tx_busy_r;

  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_sh_r    <= 11'h7FF;
      tx_cnt_r   <= 4'h0;
      tx_rt_r    <= 4'h0;
      tx_busy_r  <= 1'b0;
      pre_pend_r <= 1'b0;
      post_brk_r <= 1'b0;
      tx_load    <= 1'b0;
      tx_done    <= 1'b0;
      te_d_r     <= 1'b0;
    end
    else
    begin
      tx_load <= 1'b0;
      tx_done <= 1'b0;
      te_d_r  <= te;
      if (te & ~te_d_r)
        pre_pend_r <= 1'b1;
      if (rt_tick)
        tx_rt_r <= tx_rt_r + 4'h1;
      if (bit_stb)
      begin
        if (!last_bit)
        begin
          tx_sh_r  <= {1'b1, tx_sh_r[10:1]};
          tx_cnt_r <= tx_cnt_r - 4'h1;
        end
        else if (te && pre_pend_r)
        begin
          pre_pend_r <= 1'b0;
          tx_sh_r    <= 11'h7FF;
          tx_cnt_r   <= frame_len;
          tx_busy_r  <= 1'b1;
        end
        else if (te && sbk)
        begin
          tx_sh_r    <= 11'h000;
          tx_cnt_r   <= frame_len;
          tx_busy_r  <= 1'b1;
          post_brk_r <= 1'b1;
        end
        else if (post_brk_r)
        begin
          post_brk_r <= 1'b0;
          tx_sh_r    <= 11'h7FF;
          tx_cnt_r   <= 4'h1;
          tx_busy_r  <= 1'b1;
        end
        else if (te && !tdre_r)
        begin
          tx_sh_r   <= len9_r ? {1'b1, txb8_r, tx_hold_r, 1'b0}
                              : {2'h3, tx_hold_r, 1'b0};
          tx_cnt_r  <= frame_len;
          tx_busy_r <= 1'b1;
          tx_load   <= 1'b1;
        end
        else
        begin
          tx_done   <= tx_busy_r;
          tx_busy_r <= 1'b0;
          tx_cnt_r  <= 4'h0;
        end
      end
    end
  end

  // ==========================================================
  // Control, status and read port
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl2_r     <= `ASFE_RST_CTRL2;
      rate_r      <= `ASFE_RST_RATE;
      len9_r      <= 1'b0;
      wake_addr_r <= 1'b0;
      txb8_r      <= 1'b0;
      tx_hold_r   <= 8'h00;
      tdre_r      <= 1'b1;
      tc_r        <= 1'b1;
      rx_data_r   <= 8'h00;
      rxb8_r      <= 1'b0;
      rdrf_r      <= 1'b0;
      idle_r      <= 1'b0;
      ovr_r       <= 1'b0;
      nf_r        <= 1'b0;
      fe_r        <= 1'b0;
      clr_arm_r   <= 1'b0;
      char_seen_r <= 1'b0;
      reg_rdata   <= 8'h00;
    end
    else
    begin
      if (wr_ctrl1)
      begin
        txb8_r      <= reg_wdata[`ASFE_C1_TXB8];
        len9_r      <= reg_wdata[`ASFE_C1_LEN9];
        wake_addr_r <= reg_wdata[`ASFE_C1_WAKE];
      end
      if (wr_rate)
        rate_r <= reg_wdata[4:0];
      // Writes to the data register clear the empty flag; a load wins.
      if (wr_data)
        tx_hold_r <= reg_wdata;
      if (tx_load)
        tdre_r <= 1'b1;
      else if (wr_data)
        tdre_r <= 1'b0;
      if (tx_done)
        tc_r <= 1'b1;
      else if (wr_data || tx_load)
        tc_r <= 1'b0;
      // Reading status with a flag up, then the data, clears the flags.
      if (rd_stat)
        clr_arm_r <= rdrf_r | idle_r | ovr_r | nf_r | fe_r;
      else if (rd_data)
        clr_arm_r <= 1'b0;
      if (rd_data && clr_arm_r)
      begin
        rdrf_r <= 1'b0;
        idle_r <= 1'b0;
        ovr_r  <= 1'b0;
        nf_r   <= 1'b0;
        fe_r   <= 1'b0;
      end
      // Software writes take the sleep bit; hardware wake is skipped in that cycle.
      if (wr_ctrl2)
        ctrl2_r <= reg_wdata;
      if (rx_done && sleep && !(wr_ctrl2))
      begin
        if (wake_addr_r && msb_in)
          ctrl2_r[`ASFE_C2_SLEEP] <= 1'b0;
      end
      if (rx_idle_ev && sleep && !wake_addr_r && !(wr_ctrl2))
        ctrl2_r[`ASFE_C2_SLEEP] <= 1'b0;
      if (rx_done && (!sleep || (wake_addr_r && msb_in)))
      begin
        char_seen_r <= 1'b1;
        if (rdrf_r && !(rd_data && clr_arm_r))
          ovr_r <= 1'b1;
        else
        begin
          rx_data_r <= rx_sh_r[7:0];
          rxb8_r    <= rx_sh_r[8] & len9_r;
          rdrf_r    <= 1'b1;
          nf_r      <= rx_noise_r;
          fe_r      <= rx_ferr;
        end
      end
      if (rx_idle_ev && !sleep && char_seen_r)
      begin
        idle_r      <= 1'b1;
        char_seen_r <= 1'b0;
      end
      if (!re)
      begin
        rdrf_r <= 1'b0;
        idle_r <= 1'b0;
        ovr_r  <= 1'b0;
        nf_r   <= 1'b0;
        fe_r   <= 1'b0;
      end
      if (reg_rd)
      begin
        case (reg_addr)
          `ASFE_REG_DATA:  reg_rdata <= rx_data_r;
          `ASFE_REG_CTRL1: reg_rdata <= {rxb8_r, txb8_r, 1'b0, len9_r,
                                         wake_addr_r, 3'h0};
          `ASFE_REG_CTRL2: reg_rdata <= ctrl2_r;
          `ASFE_REG_STAT:  reg_rdata <= stat_w;
          `ASFE_REG_RATE:  reg_rdata <= {3'h0, rate_r};
          default:         reg_rdata <= 8'h00;
        endcase
      end
      else
        reg_rdata <= 8'h00;
    end
  end

  // Both directions share one tick and one format but no state.
  assign serv_req = (ctrl2_r[`ASFE_C2_TIE] & tdre_r) |
                    (ctrl2_r[`ASFE_C2_TCIE] & tc_r) |
                    (ctrl2_r[`ASFE_C2_RIE] & (rdrf_r | ovr_r)) |
                    (ctrl2_r[`ASFE_C2_ILIE] & idle_r);

endmodule // asfe_engine
